/* core/cws_pkg.sv */
// constants and types for the two-wire companion slave
package cws_pkg;
  localparam logic [3:0] ID_MEM     = 4'ha;
  localparam logic [3:0] ID_COMP    = 4'hd;
  localparam logic [7:0] REG_FLAGS  = 8'h00;
  localparam logic [7:0] REG_TRIM   = 8'h01;
  localparam logic [7:0] COMP_TOP   = 8'h18;
  localparam int         B_OSC      = 7;
  localparam int         B_CENT     = 6;
  localparam int         B_SIGN     = 5;
  localparam int         B_MODE     = 2;
  localparam int         B_FRZ      = 1;
  localparam int         B_SNAP     = 0;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] TRIM_RST   = 8'h00;
  localparam logic [7:0] TRIM_WMASK = 8'hbf;
  localparam int         MEM_AW_DEF = 15;
  localparam logic [1:0] PWR_APPLY  = 2'd2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } cws_state_type;

  typedef enum logic [2:0] {
    K_DEV = 3'b000,
    K_MAH = 3'b001,
    K_MAL = 3'b010,
    K_RA  = 3'b011,
    K_WD  = 3'b100
  } cws_kind_type;

  typedef struct packed {
    logic       osc_halt;
    logic       trim_sign;
    logic [4:0] trim_magnitude;
    logic       trim_mode;
    logic       time_freeze;
  } cws_ctl_type;
endpackage

/* core/cws_slave.sv */
// two-wire slave with memory and companion register targets
//
// Contract
// - osc_halt (01h bit 7) at 1 stops the oscillator, 0 lets it run.
// - power-up without backup source forces osc_halt to 1.
// - trim_sign picks add or subtract of five-bit trim_magnitude; both read/write.
// - years rollover 99 to 00 sets century_flag, 00h bit 6.
// - century_flag is read-only; reading register 00h clears it.
// - trim_mode 1 selects calibration output, 0 passes power-fail comparator.
// - time_freeze at 1 halts timekeeping counters for loading.
// - clearing time_freeze loads time registers into counters and resumes.
// - only a rising snapshot_take captures counters into readable registers.
// - address bits 7-4: 1010b memory, 1101b companion; companion leaves memory alone.
// - address bits 2-1 must match select pins; bit 0 set means read.
// - a Start anywhere abandons work and awaits a new address byte.
// - supply below trip level abandons the transaction; master restarts with Start.
// - a Stop during a pending operation ends and abandons it.
// - receiver acknowledges low after bit eight; high slot aborts the operation.
// - memory write sends two address bytes, upper first; unused upper bits ignored.
// - memory address increments before each acknowledge, wrapping to 0000h.
// - reads start at held memory address; companion accesses never change it.
// - companion address above 18h gets not-acknowledge and abandons the transaction.
// - bytes move eight bits MSB first; reads continue only after acknowledge.
// - memory writes on the eighth bit; earlier Start or Stop leaves memory intact.
// - separate memory and companion pointers; companion reads auto-increment too.
// - random read: write header and address, repeated Start, then read header.
`timescale 1ns/1ps
module cws_slave #(
  parameter int MEM_AW = cws_pkg::MEM_AW_DEF
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  input  wire logic [1:0]         dev_sel,
  input  wire logic               supply_ok,
  input  wire logic               backup_present,
  input  wire logic               powerfail_cmp,
  input  wire logic               trim_clk_in,
  output logic                    trim_or_powerfail_out,
  output cws_pkg::cws_ctl_type    ctl,
  input  wire logic               tb_clk,
  input  wire logic               years_rollover,
  output logic                    freeze_tb,
  output logic                    load_strobe,
  output logic                    snapshot_strobe
);
  cws_pkg::cws_state_type st_q, st_d;
  cws_pkg::cws_kind_type  kind_q, kind_d, kind_nxt;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic        pend_q, pend_d, ack_q, ack_d, ackd_q, ackd_d;
  logic        rd_q, tgt_q;
  logic [7:0]  hi_q;
  logic [MEM_AW-1:0] mem_ptr_q;
  logic [4:0]  comp_ptr_q;
  logic [7:0]  mem [0:(1<<MEM_AW)-1];
  logic [7:0]  comp_ram [0:24];
  logic [2:0]  flg_q;
  logic [7:0]  trim_q;
  logic        century_q;
  logic [1:0]  pwr_cnt_q;
  logic        snap_tgl_q, tpo_q;
  logic        scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic        sup_m, sup_s, bak_m, bak_s, pf_m, pf_s, tc_m, tc_s;
  logic [1:0]  sel_m, sel_s;
  logic        yr_m, yr_s, yr_p;
  logic        yr_tgl_q, sn_m, sn_s, sn_p, fz_m, fz_s, fz_p;
  logic        snap_str_q, load_str_q;

  // pin synchronisers, then one extra stage on scl and sda for edge detection
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
      {sup_m, sup_s, bak_m, bak_s} <= 4'h0;
      {pf_m, pf_s, tc_m, tc_s} <= 4'h0;
      {sel_m, sel_s} <= 4'h0;
    end
    else if (ce)
    begin
      {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
      {sup_m, sup_s, bak_m, bak_s} <= {supply_ok, sup_m, backup_present, bak_m};
      {pf_m, pf_s, tc_m, tc_s} <= {powerfail_cmp, pf_m, trim_clk_in, tc_m};
      {sel_m, sel_s} <= {dev_sel, sel_m};
    end

  // bus conditions
  // clock edges, start and stop
  wire scl_rise  = scl_s & ~scl_p;
  wire scl_fall  = ~scl_s & scl_p;
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det  = scl_s & scl_p & ~sda_p & sda_s;

  wire [7:0] rx_byte  = {sh_q[6:0], sda_s};
  wire       byte_done = (st_q == cws_pkg::ST_RX) & scl_rise & ~pend_q & (bit_q == 3'd7);
  wire [3:0] id       = rx_byte[7:4];
  wire       is_comp  = id == cws_pkg::ID_COMP;
  wire       dev_ok   = (id == cws_pkg::ID_MEM | is_comp) & (rx_byte[2:1] == sel_s);
  wire       ra_ok    = rx_byte <= cws_pkg::COMP_TOP;
  wire       byte_ack = (kind_q == cws_pkg::K_DEV) ? dev_ok :
                        (kind_q == cws_pkg::K_RA) ? ra_ok : 1'b1;
  assign kind_nxt = (kind_q == cws_pkg::K_DEV) ? (is_comp ? cws_pkg::K_RA : cws_pkg::K_MAH) :
                    (kind_q == cws_pkg::K_MAH) ? cws_pkg::K_MAL : cws_pkg::K_WD;

  wire tx_end   = (st_q == cws_pkg::ST_TX) & scl_fall & (bit_q == 3'd7);
  wire wd_done  = byte_done & (kind_q == cws_pkg::K_WD);
  wire mem_inc  = ~tgt_q & (wd_done | tx_end);
  wire comp_inc = tgt_q & (wd_done | tx_end);
  wire load_rd  = scl_fall & (((st_q == cws_pkg::ST_ACK) & rd_q) | ((st_q == cws_pkg::ST_MACK) & ackd_q));
  wire [15:0] addr_full = {hi_q, rx_byte};
  wire [4:0]  comp_nxt  = (comp_ptr_q == cws_pkg::COMP_TOP[4:0]) ? 5'h00 : comp_ptr_q + 5'h01;

  wire [7:0] flags_rd = {1'b0, century_q, 3'b000, flg_q};
  wire [7:0] trim_rd  = trim_q & cws_pkg::TRIM_WMASK;
  wire [7:0] comp_rd  = (comp_ptr_q == cws_pkg::REG_FLAGS[4:0]) ? flags_rd :
                        (comp_ptr_q == cws_pkg::REG_TRIM[4:0]) ? trim_rd : comp_ram[comp_ptr_q];
  wire [7:0] rd_byte  = tgt_q ? comp_rd : mem[mem_ptr_q];

  always_comb
  begin
    st_d   = st_q;
    kind_d = kind_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    pend_d = pend_q;
    ack_d  = ack_q;
    ackd_d = ackd_q;
    if (!sup_s)
      st_d = cws_pkg::ST_IDLE;
    else if (start_det)
    begin
      st_d   = cws_pkg::ST_RX;
      kind_d = cws_pkg::K_DEV;
      bit_d  = 3'd0;
      pend_d = 1'b0;
    end
    else if (stop_det)
      st_d = cws_pkg::ST_IDLE;
    else
      case (st_q)
        cws_pkg::ST_RX:
          if (pend_q && scl_fall)
          begin
            st_d   = ack_q ? cws_pkg::ST_ACK : cws_pkg::ST_IDLE;
            pend_d = 1'b0;
          end
          else if (scl_rise && !pend_q)
          begin
            sh_d  = rx_byte;
            bit_d = bit_q + 3'd1;
            if (bit_q == 3'd7)
            begin
              pend_d = 1'b1;
              ack_d  = byte_ack;
              kind_d = kind_nxt;
            end
          end
        cws_pkg::ST_ACK:
          if (scl_fall)
          begin
            bit_d = 3'd0;
            if (rd_q)
            begin
              st_d = cws_pkg::ST_TX;
              sh_d = rd_byte;
            end
            else
              st_d = cws_pkg::ST_RX;
          end
        cws_pkg::ST_TX:
          if (scl_fall)
          begin
            bit_d = bit_q + 3'd1;
            if (bit_q == 3'd7)
            begin
              st_d   = cws_pkg::ST_MACK;
              ackd_d = 1'b0;
            end
            else
              sh_d = {sh_q[6:0], 1'b0};
          end
        cws_pkg::ST_MACK:
          if (scl_rise)
          begin
            if (sda_s)
              st_d = cws_pkg::ST_IDLE;
            else
              ackd_d = 1'b1;
          end
          else if (scl_fall && ackd_q)
          begin
            st_d  = cws_pkg::ST_TX;
            sh_d  = rd_byte;
            bit_d = 3'd0;
          end
        default: st_d = cws_pkg::ST_IDLE;
      endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      st_q   <= cws_pkg::ST_IDLE;
      kind_q <= cws_pkg::K_DEV;
      {bit_q, sh_q, pend_q, ack_q, ackd_q} <= 14'h0000;
    end
    else if (ce)
    begin
      st_q   <= st_d;
      kind_q <= kind_d;
      {bit_q, sh_q, pend_q, ack_q, ackd_q} <= {bit_d, sh_d, pend_d, ack_d, ackd_d};
    end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((st_q == cws_pkg::ST_ACK) | ((st_q == cws_pkg::ST_TX) & ~sh_q[7]));

  // header and pointers
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      {rd_q, tgt_q, hi_q} <= 10'h000;
    else if (ce && byte_done)
    begin
      if (kind_q == cws_pkg::K_DEV && dev_ok)
        {rd_q, tgt_q} <= {rx_byte[0], is_comp};
      if (kind_q == cws_pkg::K_MAH)
        hi_q <= rx_byte;
    end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      mem_ptr_q <= '0;
    else if (ce && byte_done && kind_q == cws_pkg::K_MAL)
      mem_ptr_q <= addr_full[MEM_AW-1:0];
    else if (ce && mem_inc)
      mem_ptr_q <= mem_ptr_q + 1'b1;

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      comp_ptr_q <= 5'h00;
    else if (ce && byte_done && kind_q == cws_pkg::K_RA && ra_ok)
      comp_ptr_q <= rx_byte[4:0];
    else if (ce && comp_inc)
      comp_ptr_q <= comp_nxt;

  always_ff @(posedge mclk)
    if (ce && wd_done && !tgt_q)
      mem[mem_ptr_q] <= rx_byte;

  always_ff @(posedge mclk)
    if (ce && wd_done && tgt_q && comp_ptr_q > cws_pkg::REG_TRIM[4:0])
      comp_ram[comp_ptr_q] <= rx_byte;

  wire wr_flags = wd_done & tgt_q & (comp_ptr_q == cws_pkg::REG_FLAGS[4:0]);
  wire wr_trim  = wd_done & tgt_q & (comp_ptr_q == cws_pkg::REG_TRIM[4:0]);
  wire snap_rise = wr_flags & rx_byte[cws_pkg::B_SNAP] & ~flg_q[cws_pkg::B_SNAP];
  wire cent_set  = yr_s ^ yr_p;
  wire cent_clr  = load_rd & tgt_q & (comp_ptr_q == cws_pkg::REG_FLAGS[4:0]);

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      flg_q      <= cws_pkg::FLAGS_RST[2:0];
      snap_tgl_q <= 1'b0;
    end
    else if (ce && wr_flags)
    begin
      flg_q      <= rx_byte[2:0];
      snap_tgl_q <= snap_tgl_q ^ snap_rise;
    end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      trim_q <= cws_pkg::TRIM_RST;
    else if (ce && wr_trim)
      trim_q <= rx_byte & cws_pkg::TRIM_WMASK;
    else if (ce && pwr_cnt_q == cws_pkg::PWR_APPLY && !bak_s)
      trim_q[cws_pkg::B_OSC] <= 1'b1;

  // wait for backup sync to fill
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      pwr_cnt_q <= 2'd0;
    else if (ce && pwr_cnt_q != 2'd3)
      pwr_cnt_q <= pwr_cnt_q + 2'd1;

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      century_q <= cws_pkg::FLAGS_RST[cws_pkg::B_CENT];
    else if (ce && (cent_set || cent_clr))
      century_q <= cent_set;

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      tpo_q <= 1'b0;
    else if (ce)
      tpo_q <= flg_q[cws_pkg::B_MODE] ? tc_s : pf_s;

  assign trim_or_powerfail_out = tpo_q;
  assign ctl = '{osc_halt: trim_q[cws_pkg::B_OSC], trim_sign: trim_q[cws_pkg::B_SIGN],
                 trim_magnitude: trim_q[4:0], trim_mode: flg_q[cws_pkg::B_MODE],
                 time_freeze: flg_q[cws_pkg::B_FRZ]};

  // rollover toggle into mclk
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      {yr_m, yr_s, yr_p} <= 3'b000;
    else if (ce)
      {yr_m, yr_s, yr_p} <= {yr_tgl_q, yr_m, yr_s};

  // timebase domain
  always_ff @(posedge tb_clk or negedge reset_n)
    if (!reset_n)
    begin
      {yr_tgl_q, sn_m, sn_s, sn_p, fz_m, fz_s, fz_p} <= 7'h00;
      {snap_str_q, load_str_q} <= 2'b00;
    end
    else
    begin
      yr_tgl_q <= yr_tgl_q ^ years_rollover;
      {sn_m, sn_s, sn_p} <= {snap_tgl_q, sn_m, sn_s};
      {fz_m, fz_s, fz_p} <= {flg_q[cws_pkg::B_FRZ], fz_m, fz_s};
      snap_str_q <= sn_s ^ sn_p;
      load_str_q <= fz_p & ~fz_s;
    end

  assign freeze_tb       = fz_s;
  assign snapshot_strobe = snap_str_q;
  assign load_strobe     = load_str_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_start_rearm: assert property (ce && sup_s && start_det |=>
    st_q == cws_pkg::ST_RX && kind_q == cws_pkg::K_DEV && bit_q == 3'd0) else $error("start not rearmed");
  a_stop_abandon: assert property (ce && sup_s && stop_det |=> st_q == cws_pkg::ST_IDLE)
    else $error("stop did not abandon");
  a_supply_abort: assert property (ce && !sup_s |=> st_q == cws_pkg::ST_IDLE && sda_oe_n)
    else $error("supply trip not honoured");
  a_nack_end: assert property (ce && st_q == cws_pkg::ST_MACK && scl_rise && sda_s && sup_s
    && !stop_det |=> st_q == cws_pkg::ST_IDLE ##1 sda_oe_n) else $error("nack did not end read");
  a_range_nack: assert property (ce && byte_done && kind_q == cws_pkg::K_RA && !ra_ok && sup_s
    && !start_det |=> !ack_q) else $error("bad register address acked");
  a_sel_match: assert property (ce && byte_done && kind_q == cws_pkg::K_DEV && sup_s
    && rx_byte[2:1] != sel_s |=> !ack_q) else $error("wrong select acked");
  a_mem_wrap: assert property (ce && mem_inc && mem_ptr_q == {MEM_AW{1'b1}} |=> mem_ptr_q == '0)
    else $error("memory address did not wrap");
  a_century_set: assert property (ce && cent_set |=> century_q)
    else $error("century flag not set");
  a_century_clear: assert property (ce && cent_clr && !cent_set |=> !century_q)
    else $error("century flag not cleared");
  a_osc_boot: assert property (ce && pwr_cnt_q == cws_pkg::PWR_APPLY && !bak_s |=> ctl.osc_halt)
    else $error("oscillator not halted at boot");
  a_snap_toggle: assert property (ce && snap_rise |=> snap_tgl_q != $past(snap_tgl_q))
    else $error("snapshot edge lost");

  c_mem_write: cover property (ce && wd_done && !tgt_q);
  c_comp_read: cover property (ce && load_rd && tgt_q);
  c_restart: cover property (ce && start_det && st_q == cws_pkg::ST_ACK);
endmodule

/* testbench/cws_master.sv */
// two-wire bus master model for the slave's link pins
`timescale 1ns/1ps
module cws_master (
  input  wire logic mclk,
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_w
);
  // bus idles high, clock stands still outside frames
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one bit: data set while clock low, wire sampled seven cycles into the eight-cycle high
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    cyc(4);
    scl <= 1'b1;
    cyc(7);
    r = sda_w;
    cyc(1);
    scl <= 1'b0;
    cyc(4);
  endtask

  // every operation opens with a start
  task automatic start;
    sda_m <= 1'b1;
    cyc(4);
    scl <= 1'b1;
    cyc(6);
    sda_m <= 1'b0;
    cyc(6);
    scl <= 1'b0;
    cyc(2);
  endtask

  task automatic stop;
    sda_m <= 1'b0;
    cyc(4);
    scl <= 1'b1;
    cyc(6);
    sda_m <= 1'b1;
    cyc(8);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // final byte gets a high slot
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask

  task automatic part_byte(input logic [7:0] d, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--)
      bit_x(d[i], r);
  endtask
endmodule

/* testbench/tb_cws_slave.sv */
// self-checking bench for the two-wire companion slave
`timescale 1ns/1ps
module tb_cws_slave;
  localparam logic [1:0] DSEL = 2'b10;
  logic                 mclk = 1'b0;
  logic                 tb_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 powerfail_cmp = 1'b0;
  logic                 trim_clk_in = 1'b0;
  logic                 years_rollover = 1'b0;
  logic                 ce = 1'b1;
  logic                 supply_ok = 1'b1;
  logic                 backup_present = 1'b0;
  logic                 scl, sda_m, sda_out, sda_oe_n, tpo, freeze_tb, load_strobe, snapshot_strobe;
  wire logic            sda_w;
  cws_pkg::cws_ctl_type ctl;
  int                   err_total = 0;
  int                   compares = 0;
  int                   n_load = 0;
  int                   n_snap = 0;

  always #20 mclk = ~mclk;
  always #24 tb_clk = ~tb_clk;
  assign sda_w = sda_m & (sda_oe_n | sda_out);

  always @(posedge tb_clk)
  begin
    n_load <= n_load + int'(load_strobe === 1'b1);
    n_snap <= n_snap + int'(snapshot_strobe === 1'b1);
  end

  cws_master m_u (.mclk(mclk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));

  cws_slave #(.MEM_AW(8)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .dev_sel(DSEL), .supply_ok(supply_ok), .backup_present(backup_present),
    .powerfail_cmp(powerfail_cmp), .trim_clk_in(trim_clk_in), .trim_or_powerfail_out(tpo), .ctl(ctl),
    .tb_clk(tb_clk), .years_rollover(years_rollover), .freeze_tb(freeze_tb), .load_strobe(load_strobe),
    .snapshot_strobe(snapshot_strobe)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // target id, select bits and direction
  task automatic hdr(input logic [3:0] id, input logic [1:0] sel, input logic rw, output logic a);
    m_u.start;
    m_u.wr_byte({id, 1'b0, sel, rw}, a);
  endtask

  task automatic cwr(input logic [7:0] ra, input logic [7:0] d);
    logic [2:0] a;
    hdr(cws_pkg::ID_COMP, DSEL, 1'b0, a[0]);
    m_u.wr_byte(ra, a[1]);
    m_u.wr_byte(d, a[2]);
    m_u.stop;
    check(a, 3'h7, "reg write ack");
  endtask

  task automatic crd(input logic [7:0] ra, output logic [7:0] d);
    logic [2:0] a;
    hdr(cws_pkg::ID_COMP, DSEL, 1'b0, a[0]);
    m_u.wr_byte(ra, a[1]);
    hdr(cws_pkg::ID_COMP, DSEL, 1'b1, a[2]);
    m_u.rd_byte(1'b1, d);
    m_u.stop;
    check(a, 3'h7, "reg read ack");
  endtask

  task automatic t_boot;
    logic [7:0] q;
    check(ctl.osc_halt, 1'b1, "boot halt");
    crd(cws_pkg::REG_TRIM, q);
    check(q, 8'h80, "boot trim");
    $display("boot test done");
  endtask

  task automatic t_trim;
    logic [7:0] q;
    cwr(cws_pkg::REG_TRIM, 8'h7f);
    crd(cws_pkg::REG_TRIM, q);
    check(q, 8'h3f, "trim readback");
    check(ctl, 9'h0fc, "ctl fields");
    cwr(cws_pkg::REG_TRIM, 8'h85);
    check(ctl, 9'h114, "ctl halt");
    $display("trim test done");
  endtask

  task automatic t_mem;
    logic [9:0] a;
    logic [7:0] q0, q1, q2;
    hdr(cws_pkg::ID_MEM, DSEL, 1'b0, a[0]);
    // upper address byte sent as zero
    m_u.wr_byte(8'h00, a[1]);
    m_u.wr_byte(8'hff, a[2]);
    m_u.wr_byte(8'ha5, a[3]);
    m_u.wr_byte(8'h3c, a[4]);
    m_u.wr_byte(8'h96, a[5]);
    m_u.stop;
    hdr(cws_pkg::ID_MEM, DSEL, 1'b0, a[6]);
    m_u.wr_byte(8'h00, a[7]);
    m_u.wr_byte(8'hff, a[8]);
    hdr(cws_pkg::ID_MEM, DSEL, 1'b1, a[9]);
    m_u.rd_byte(1'b0, q0);
    m_u.rd_byte(1'b1, q1);
    m_u.stop;
    check(a, 10'h3ff, "mem acks");
    check(q0, 8'ha5, "random read");
    check(q1, 8'h3c, "wrap read");
    crd(cws_pkg::REG_TRIM, q2);
    hdr(cws_pkg::ID_MEM, DSEL, 1'b1, a[0]);
    m_u.rd_byte(1'b1, q2);
    m_u.stop;
    check(q2, 8'h96, "held pointer");
    $display("memory test done");
  endtask

  task automatic t_abort;
    logic [3:0] a;
    logic [7:0] q;
    hdr(cws_pkg::ID_MEM, DSEL, 1'b0, a[0]);
    m_u.wr_byte(8'h00, a[1]);
    m_u.wr_byte(8'h00, a[2]);
    // six bits only: the restart's own clock rise is taken as a data bit
    m_u.part_byte(8'h11, 6);
    hdr(cws_pkg::ID_MEM, DSEL, 1'b1, a[3]);
    m_u.rd_byte(1'b1, q);
    m_u.stop;
    check(q, 8'h3c, "start abort");
    hdr(cws_pkg::ID_MEM, DSEL, 1'b0, a[0]);
    m_u.wr_byte(8'h00, a[1]);
    m_u.wr_byte(8'h00, a[2]);
    m_u.part_byte(8'h22, 6);
    m_u.stop;
    hdr(cws_pkg::ID_MEM, DSEL, 1'b1, a[3]);
    m_u.rd_byte(1'b1, q);
    m_u.stop;
    check(q, 8'h3c, "stop abort");
    check(a, 4'hf, "abort acks");
    $display("abort test done");
  endtask

  task automatic t_refuse;
    logic [1:0] a;
    logic [7:0] q;
    hdr(4'h5, DSEL, 1'b0, a[0]);
    m_u.stop;
    check(a[0], 1'b0, "foreign id");
    hdr(cws_pkg::ID_MEM, ~DSEL, 1'b0, a[0]);
    m_u.stop;
    check(a[0], 1'b0, "select mismatch");
    hdr(cws_pkg::ID_COMP, DSEL, 1'b0, a[1]);
    m_u.wr_byte(8'h19, a[0]);
    m_u.stop;
    check(a, 2'b10, "reg range");
    cwr(8'h18, 8'h5a);
    crd(8'h18, q);
    check(q, 8'h5a, "top register");
    $display("refuse test done");
  endtask

  task automatic t_ctl;
    logic [7:0] q;
    int         l0, s0;
    l0 = n_load;
    s0 = n_snap;
    cwr(cws_pkg::REG_FLAGS, 8'h02);
    m_u.cyc(30);
    check(freeze_tb, 1'b1, "freeze");
    cwr(cws_pkg::REG_FLAGS, 8'h00);
    m_u.cyc(30);
    check(16'(n_load - l0), 16'h1, "load pulse");
    check(freeze_tb, 1'b0, "thaw");
    cwr(cws_pkg::REG_FLAGS, 8'h01);
    cwr(cws_pkg::REG_FLAGS, 8'h01);
    m_u.cyc(30);
    check(16'(n_snap - s0), 16'h1, "one capture");
    // capture bit returned to zero first
    cwr(cws_pkg::REG_FLAGS, 8'h00);
    cwr(cws_pkg::REG_FLAGS, 8'h01);
    m_u.cyc(30);
    check(16'(n_snap - s0), 16'h2, "second capture");
    @(posedge tb_clk) years_rollover <= 1'b1;
    @(posedge tb_clk) years_rollover <= 1'b0;
    m_u.cyc(10);
    cwr(cws_pkg::REG_FLAGS, 8'h44);
    crd(cws_pkg::REG_FLAGS, q);
    check(q, 8'h44, "century set");
    crd(cws_pkg::REG_FLAGS, q);
    check(q, 8'h04, "century clear");
    trim_clk_in <= 1'b1;
    m_u.cyc(8);
    check(tpo, 1'b1, "trim out");
    cwr(cws_pkg::REG_FLAGS, 8'h00);
    powerfail_cmp <= 1'b1;
    m_u.cyc(8);
    check(tpo, 1'b1, "pfail high");
    powerfail_cmp <= 1'b0;
    m_u.cyc(8);
    check(tpo, 1'b0, "pfail low");
    $display("control test done");
  endtask

  task automatic t_supply;
    logic [2:0] a;
    hdr(cws_pkg::ID_MEM, DSEL, 1'b0, a[0]);
    m_u.wr_byte(8'h00, a[1]);
    supply_ok <= 1'b0;
    m_u.cyc(8);
    supply_ok <= 1'b1;
    m_u.cyc(8);
    m_u.wr_byte(8'h00, a[2]);
    m_u.stop;
    check(a, 3'b011, "supply trip abort");
    $display("supply test done");
  endtask

  task automatic t_enable;
    logic [2:0] a;
    logic [7:0] q;
    cwr(8'h02, 8'h11);
    ce <= 1'b0;
    hdr(cws_pkg::ID_COMP, DSEL, 1'b0, a[0]);
    m_u.wr_byte(8'h02, a[1]);
    m_u.wr_byte(8'h33, a[2]);
    m_u.stop;
    ce <= 1'b1;
    m_u.cyc(4);
    check(a, 3'h0, "enable low ignores bus");
    crd(8'h02, q);
    check(q, 8'h11, "enable low keeps register");
    $display("enable test done");
  endtask

  task automatic t_backup;
    logic [7:0] q;
    reset_n <= 1'b0;
    backup_present <= 1'b1;
    m_u.cyc(4);
    reset_n <= 1'b1;
    m_u.cyc(10);
    check(ctl.osc_halt, 1'b0, "backup keeps oscillator");
    crd(cws_pkg::REG_TRIM, q);
    check(q, 8'h00, "backup trim");
    $display("backup test done");
  endtask

  initial
  begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    m_u.cyc(10);
    t_boot;
    t_trim;
    t_mem;
    t_abort;
    t_refuse;
    t_ctl;
    t_supply;
    t_enable;
    t_backup;
    end_sim;
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    err_total++;
    end_sim;
  end
endmodule
